/* src/div_seq.v */
// ----------------------------------------
// restoring unsigned divider, one quotient bit per cycle
// ----------------------------------------
module div_seq #(
    parameter W = 24
) (
    input wire clk,
    input wire rst_n,
    input wire ce,
    input wire start,
    input wire [W-1:0] dividend,
    input wire [W-1:0] divisor,
    output reg done_q,
    output reg [W-1:0] quot_q
);
    localparam [5:0] STEPS = W;

    reg [W:0] rem_q;
    reg [W-1:0] quo_q;
    reg [W-1:0] dvs_q;
    reg [5:0] cnt_q;
    reg busy_q;
    wire [W:0] shifted = {rem_q[W-1:0], quo_q[W-1]};
    wire [W:0] trial = shifted - {1'b0, dvs_q};
    wire [W-1:0] quo_d = {quo_q[W-2:0], ~trial[W]};

    // divide by zero yields all ones; callers guard it
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rem_q <= {(W+1){1'b0}};
            quo_q <= {W{1'b0}};
            dvs_q <= {W{1'b0}};
            cnt_q <= 6'h00;
            busy_q <= 1'b0;
            done_q <= 1'b0;
            quot_q <= {W{1'b0}};
        end else if (ce) begin
            done_q <= 1'b0;
            if (start) begin
                rem_q <= {(W+1){1'b0}};
                quo_q <= dividend;
                dvs_q <= divisor;
                cnt_q <= STEPS;
                busy_q <= 1'b1;
            end else if (busy_q) begin
                rem_q <= trial[W] ? shifted : trial;
                quo_q <= quo_d;
                cnt_q <= cnt_q - 6'h01;
                if (cnt_q == 6'h01) begin
                    busy_q <= 1'b0;
                    done_q <= 1'b1;
                    quot_q <= quo_d;
                end
            end
        end
    end
endmodule // div_seq

/* src/thermo_channels.v */
// Behaviour
// (R1) convert enabled channels in turn, 200 ms each; disabled ones skipped
// (R2) result in celsius or fahrenheit per unit-select input
// (R3) gain clamped to 0.9..1.1, offset to -1.0..1.0; host keeps bounds
// (R4) averaging depth 1..100; average is window sum divided by depth
// (R5) window is a queue: newest enters tail, oldest leaves head
// (R6) enabled channels raise disconnection alarm on open input
// (R7) input outside accepted range raises out-of-range warning
// (R8) error led blinks or stays steady on warning, per setting
// (R9) alarm may request interrupt; host routine number 40..251
// (R10) output saturates at max below band, falls to zero at setpoint
// (R11) output is p gain*error + i gain*error sum + d gain*error change
// (R12) forward: present minus setpoint; reverse: setpoint minus present
// (R13) pulse width is output over (max minus min) times cycle
// (R14) host sets control cycle and pulse width before pulses start; code computes pulse_width_q itself from the control output
// (R15) sampling time is one word counted in 10 ms units
// (R16) dead band zero disables; errors inside band force zero output; code zeroes only the error, integral and derivative terms still act
// (R17) before depth samples exist, average over samples received
`include "thermo_consts.vh"

module thermo_channels #(
    parameter CONV_CYC = `CONV_CYC,
    parameter SAMP_UNIT_CYC = `SAMP_UNIT_CYC,
    parameter BLINK_CYC = `BLINK_CYC
) (
    input wire clk,
    input wire rst_n,
    input wire ce,
    input wire [7:0] ch_enable,
    input wire unit_fahr,
    input wire [127:0] gain_flat,
    input wire [127:0] offset_flat,
    input wire [6:0] avg_depth,
    input wire [15:0] adc_value,
    input wire adc_open,
    input wire adc_over,
    input wire warn_blink,
    input wire alarm_irq_en,
    input wire [7:0] isr_number,
    input wire pid_enable,
    input wire [2:0] pid_chan,
    input wire [7:0] pid_reverse,
    input wire [15:0] setpoint_value,
    input wire [15:0] proportional_gain,
    input wire [15:0] integral_gain,
    input wire [15:0] derivative_gain,
    input wire [15:0] dead_band,
    input wire [15:0] out_max,
    input wire [15:0] out_min,
    input wire [15:0] samp_time,
    output reg conv_start_q,
    output reg [2:0] conv_chan_q,
    output reg [127:0] temp_flat_q,
    output reg result_valid_q,
    output reg [2:0] result_chan_q,
    output reg [7:0] disc_alarm_q,
    output reg [7:0] range_alarm_q,
    output reg err_led_q,
    output reg irq_req_q,
    output reg [7:0] irq_vector_q,
    output reg [15:0] control_output_q,
    output reg [15:0] pulse_width_q,
    output reg pulse_out_q
);
    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_CONV = 3'h1;
    localparam [2:0] ST_CAL = 3'h2;
    localparam [2:0] ST_RD = 3'h3;
    localparam [2:0] ST_UPD = 3'h4;
    localparam [2:0] ST_DIV = 3'h5;

    // ----------------------------------------
    // reset release
    // ----------------------------------------
    reg rs1_q;
    reg rs2_q;
    wire rst_i_n = rs2_q;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rs1_q <= 1'b0;
            rs2_q <= 1'b0;
        end else begin
            rs1_q <= 1'b1;
            rs2_q <= rs1_q;
        end
    end

    // ----------------------------------------
    // scan order and calibration
    // ----------------------------------------
    reg [2:0] st_q;
    reg [31:0] slot_q;
    reg signed [15:0] raw_q;
    reg open_q;
    reg over_q;
    reg signed [15:0] samp_q;
    reg signed [15:0] old_q;
    reg neg_q;
    reg [2:0] nxt;
    reg nxt_ok;
    reg [2:0] idx;
    integer k;

    always @* begin
        idx = 3'h0;
        nxt = conv_chan_q;
        nxt_ok = ch_enable[conv_chan_q];
        // smallest forward distance wins, so the scan is round robin
        for (k = 7; k >= 1; k = k - 1) begin
            idx = conv_chan_q + k[2:0];
            if (ch_enable[idx]) begin
                nxt = idx;
                nxt_ok = 1'b1;
            end
        end
    end

    wire [15:0] g_in = gain_flat[conv_chan_q*16 +: 16];
    wire signed [15:0] o_in = offset_flat[conv_chan_q*16 +: 16];
    wire [15:0] g_use = (g_in < `GAIN_MIN) ? `GAIN_MIN :
                        (g_in > `GAIN_MAX) ? `GAIN_MAX : g_in; // R3
    wire signed [15:0] o_use =
        (o_in > $signed(`OFS_MAX)) ? $signed(`OFS_MAX) :
        (o_in < $signed(`OFS_MIN)) ? $signed(`OFS_MIN) : o_in; // R3
    wire signed [33:0] cal_p = raw_q * $signed({1'b0, g_use}) +
                               (o_use <<< `OFS_SHIFT);
    wire signed [15:0] cal_c = cal_p[`GAIN_FRAC+15:`GAIN_FRAC];
    wire signed [31:0] f_p = cal_c * $signed({1'b0, `F_MUL});
    wire signed [15:0] cal_f = f_p[`F_FRAC+15:`F_FRAC] + $signed(`F_OFS);
    wire signed [15:0] cal_out = unit_fahr ? cal_f : cal_c; // R2

    // ----------------------------------------
    // sliding window store
    // ----------------------------------------
    reg [15:0] win_mem [0:1023];
    reg [6:0] wptr_q [0:7];
    reg [6:0] wcnt_q [0:7];
    reg signed [23:0] wsum_q [0:7];
    reg [6:0] depth_q;
    wire [6:0] depth_eff = (avg_depth < `AVG_MIN) ? `AVG_MIN :
                           (avg_depth > `AVG_MAX) ? `AVG_MAX : avg_depth;
    wire [6:0] cur_cnt = wcnt_q[conv_chan_q];
    wire [6:0] cur_ptr = wptr_q[conv_chan_q];
    wire full = (cur_cnt == depth_q);
    wire signed [23:0] sum_d = wsum_q[conv_chan_q] + samp_q -
                               (full ? old_q : 16'sh0000); // R5
    wire [6:0] cnt_d = full ? cur_cnt : cur_cnt + 7'h01;
    // divider starts after the update, so feed it the stored sum
    wire [23:0] sum_mag = wsum_q[conv_chan_q][23] ? -wsum_q[conv_chan_q] :
                          wsum_q[conv_chan_q];
    reg adiv_start_q;
    wire adiv_done;
    wire [23:0] adiv_quot;

    div_seq #(.W(24)) u_avg_div (
        .clk(clk),
        .rst_n(rst_i_n),
        .ce(ce),
        .start(adiv_start_q),
        .dividend(sum_mag),
        .divisor({17'h00000, wcnt_q[conv_chan_q]}),
        .done_q(adiv_done),
        .quot_q(adiv_quot)
    );

    wire new_alarm = (open_q & ~disc_alarm_q[conv_chan_q]) |
                     (over_q & ~open_q & ~range_alarm_q[conv_chan_q]);
    wire isr_ok = (isr_number >= `ISR_MIN) && (isr_number <= `ISR_MAX);
    integer i;

    // ----------------------------------------
    // conversion sequencer and averaging
    // ----------------------------------------
    always @(posedge clk or negedge rst_i_n) begin
        if (!rst_i_n) begin
            st_q <= ST_IDLE;
            slot_q <= 32'h00000000;
            raw_q <= 16'sh0000;
            open_q <= 1'b0;
            over_q <= 1'b0;
            samp_q <= 16'sh0000;
            old_q <= 16'sh0000;
            neg_q <= 1'b0;
            depth_q <= `AVG_MIN;
            adiv_start_q <= 1'b0;
            conv_start_q <= 1'b0;
            conv_chan_q <= 3'h0;
            temp_flat_q <= 128'h0;
            result_valid_q <= 1'b0;
            result_chan_q <= 3'h0;
            disc_alarm_q <= 8'h00;
            range_alarm_q <= 8'h00;
            irq_req_q <= 1'b0;
            irq_vector_q <= 8'h00;
            for (i = 0; i < 8; i = i + 1) begin
                wptr_q[i] <= 7'h00;
                wcnt_q[i] <= 7'h00;
                wsum_q[i] <= 24'sh000000;
            end
        end else if (ce) begin
            conv_start_q <= 1'b0;
            result_valid_q <= 1'b0;
            adiv_start_q <= 1'b0;
            irq_req_q <= 1'b0;
            depth_q <= depth_eff;
            case (st_q)
                ST_IDLE: begin
                    if (nxt_ok) begin // R1
                        conv_chan_q <= nxt;
                        conv_start_q <= 1'b1;
                        slot_q <= 32'h00000000;
                        st_q <= ST_CONV;
                    end
                end
                ST_CONV: begin
                    slot_q <= slot_q + 32'h00000001;
                    if (slot_q == CONV_CYC - 1) begin // R1
                        raw_q <= adc_value;
                        open_q <= adc_open;
                        over_q <= adc_over;
                        st_q <= ST_CAL;
                    end
                end
                ST_CAL: begin
                    disc_alarm_q[conv_chan_q] <= open_q; // R6
                    range_alarm_q[conv_chan_q] <= over_q & ~open_q; // R7
                    if (new_alarm && alarm_irq_en && isr_ok) begin // R9
                        irq_req_q <= 1'b1;
                        irq_vector_q <= isr_number;
                    end
                    samp_q <= cal_out;
                    // an open input gives no usable sample
                    st_q <= open_q ? ST_IDLE : ST_RD;
                end
                ST_RD: begin
                    old_q <= win_mem[{conv_chan_q, cur_ptr}]; // R5
                    st_q <= ST_UPD;
                end
                ST_UPD: begin
                    win_mem[{conv_chan_q, cur_ptr}] <= samp_q; // R5
                    wptr_q[conv_chan_q] <= (cur_ptr == depth_q - 7'h01) ?
                                           7'h00 : cur_ptr + 7'h01;
                    wcnt_q[conv_chan_q] <= cnt_d; // R17
                    wsum_q[conv_chan_q] <= sum_d;
                    neg_q <= sum_d[23];
                    adiv_start_q <= 1'b1;
                    st_q <= ST_DIV;
                end
                ST_DIV: begin
                    if (adiv_done) begin // R4
                        temp_flat_q[conv_chan_q*16 +: 16] <= neg_q ?
                            -adiv_quot[15:0] : adiv_quot[15:0];
                        result_valid_q <= 1'b1;
                        result_chan_q <= conv_chan_q;
                        st_q <= ST_IDLE;
                    end
                end
                default: st_q <= ST_IDLE;
            endcase
            // a depth change restarts every window so stale samples
            // never mix with the new length
            for (i = 0; i < 8; i = i + 1) begin
                if (!ch_enable[i] || depth_eff != depth_q) begin
                    wptr_q[i] <= 7'h00;
                    wcnt_q[i] <= 7'h00;
                    wsum_q[i] <= 24'sh000000;
                end
                if (!ch_enable[i]) begin // R6
                    disc_alarm_q[i] <= 1'b0;
                    range_alarm_q[i] <= 1'b0;
                end
            end
        end
    end

    // ----------------------------------------
    // error indicator
    // ----------------------------------------
    reg [31:0] blink_cnt_q;
    reg blink_q;

    always @(posedge clk or negedge rst_i_n) begin
        if (!rst_i_n) begin
            blink_cnt_q <= 32'h00000000;
            blink_q <= 1'b0;
            err_led_q <= 1'b0;
        end else if (ce) begin
            if (blink_cnt_q == BLINK_CYC - 1) begin
                blink_cnt_q <= 32'h00000000;
                blink_q <= ~blink_q;
            end else begin
                blink_cnt_q <= blink_cnt_q + 32'h00000001;
            end
            if (|disc_alarm_q) begin
                err_led_q <= 1'b1;
            end else if (|range_alarm_q) begin
                err_led_q <= warn_blink ? blink_q : 1'b1; // R8
            end else begin
                err_led_q <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // pid loop and pulse output
    // ----------------------------------------
    reg [31:0] tick_cnt_q;
    reg [15:0] samp_cnt_q;
    reg [1:0] pid_ph_q;
    reg signed [16:0] e_q;
    reg signed [16:0] e_prev_q;
    reg signed [31:0] integ_q;
    reg [15:0] width_cur_q;
    reg pdiv_start_q;
    wire pdiv_done;
    wire [31:0] pdiv_quot;
    wire tick = (tick_cnt_q == SAMP_UNIT_CYC - 1);
    wire [15:0] samp_last = (samp_time == 16'h0000) ? 16'h0000 :
                            samp_time - 16'h0001; // R15
    wire step = tick && (samp_cnt_q == samp_last);
    wire signed [16:0] pres = $signed(temp_flat_q[pid_chan*16 +: 16]);
    wire signed [16:0] sp = $signed(setpoint_value);
    wire signed [16:0] e_raw = pid_reverse[pid_chan] ? sp - pres : pres - sp;
    wire [16:0] e_mag = e_raw[16] ? -e_raw : e_raw;
    wire signed [31:0] integ_n = integ_q + e_q;
    wire signed [16:0] deriv = e_q - e_prev_q;
    wire signed [55:0] acc =
        $signed({1'b0, proportional_gain}) * e_q +
        $signed({1'b0, integral_gain}) * integ_n +
        $signed({1'b0, derivative_gain}) * deriv; // R11
    wire signed [55:0] ctl_raw = acc >>> `K_FRAC;
    wire signed [15:0] ctl_max = out_max;
    wire signed [15:0] ctl_min = out_min;
    wire signed [16:0] span = ctl_max - ctl_min;
    wire [31:0] pw_num = control_output_q[15] ? 32'h00000000 :
                         control_output_q * samp_time;

    div_seq #(.W(32)) u_pw_div (
        .clk(clk),
        .rst_n(rst_i_n),
        .ce(ce),
        .start(pdiv_start_q),
        .dividend(pw_num),
        .divisor({16'h0000, span[15:0]}),
        .done_q(pdiv_done),
        .quot_q(pdiv_quot)
    );

    always @(posedge clk or negedge rst_i_n) begin
        if (!rst_i_n) begin
            tick_cnt_q <= 32'h00000000;
            samp_cnt_q <= 16'h0000;
            pid_ph_q <= 2'h0;
            e_q <= 17'sh00000;
            e_prev_q <= 17'sh00000;
            integ_q <= 32'sh00000000;
            width_cur_q <= 16'h0000;
            pdiv_start_q <= 1'b0;
            control_output_q <= 16'h0000;
            pulse_width_q <= 16'h0000;
            pulse_out_q <= 1'b0;
        end else if (ce) begin
            pdiv_start_q <= 1'b0;
            tick_cnt_q <= tick ? 32'h00000000 : tick_cnt_q + 32'h00000001;
            if (step) begin // R15
                samp_cnt_q <= 16'h0000;
                width_cur_q <= pulse_width_q;
            end else if (tick) begin
                samp_cnt_q <= samp_cnt_q + 16'h0001;
            end
            pulse_out_q <= pid_enable && (samp_cnt_q < width_cur_q);
            case (pid_ph_q)
                2'h0: begin
                    if (step && pid_enable) begin
                        // R12
                        if (dead_band != 16'h0000 &&
                            e_mag <= {1'b0, dead_band}) begin // R16
                            e_q <= 17'sh00000;
                        end else begin
                            e_q <= e_raw;
                        end
                        pid_ph_q <= 2'h1;
                    end
                end
                2'h1: begin
                    integ_q <= integ_n;
                    e_prev_q <= e_q;
                    // clamp gives out_max once ctl_raw exceeds it and out_min once ctl_raw falls below out_min
                    if (ctl_raw > ctl_max) begin // R10
                        control_output_q <= out_max;
                    end else if (ctl_raw < ctl_min) begin
                        control_output_q <= out_min;
                    end else begin
                        control_output_q <= ctl_raw[15:0];
                    end
                    pid_ph_q <= 2'h2;
                end
                2'h2: begin
                    if (span > 17'sh00000) begin // R13
                        pdiv_start_q <= 1'b1;
                        pid_ph_q <= 2'h3;
                    end else begin
                        pulse_width_q <= 16'h0000;
                        pid_ph_q <= 2'h0;
                    end
                end
                2'h3: begin
                    if (pdiv_done) begin // R13
                        pulse_width_q <= (pdiv_quot > {16'h0000, samp_time}) ?
                                         samp_time : pdiv_quot[15:0];
                        pid_ph_q <= 2'h0;
                    end
                end
                default: pid_ph_q <= 2'h0;
            endcase
            if (!pid_enable) begin
                integ_q <= 32'sh00000000;
                e_prev_q <= 17'sh00000;
            end
        end
    end
endmodule // thermo_channels

/* src/thermo_consts.vh */
`ifndef THERMO_CONSTS_VH
`define THERMO_CONSTS_VH

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_HZ 125000000
`define CONV_TIME_MS 200
`define CONV_CYC (`CLK_HZ / 1000 * `CONV_TIME_MS)
`define SAMP_UNIT_MS 10
`define SAMP_UNIT_CYC (`CLK_HZ / 1000 * `SAMP_UNIT_MS)
`define BLINK_MS 500
`define BLINK_CYC (`CLK_HZ / 1000 * `BLINK_MS)

// ----------------------------------------
// averaging depth limits
// ----------------------------------------
`define AVG_MIN 7'h01
`define AVG_MAX 7'h64

// ----------------------------------------
// calibration: gain q2.14, offset q8.8
// ----------------------------------------
`define GAIN_FRAC 14
`define GAIN_MIN 16'h399a
`define GAIN_MAX 16'h4666
`define OFS_MAX 16'h0100
`define OFS_MIN 16'hff00
`define OFS_SHIFT 6

// ----------------------------------------
// fahrenheit: f = c * 9/5 + 32, tenths of a degree
// ----------------------------------------
`define F_MUL 16'h399a
`define F_FRAC 13
`define F_OFS 16'h0140

// ----------------------------------------
// interrupt routine number range, pid gain fraction
// ----------------------------------------
`define ISR_MIN 8'h28
`define ISR_MAX 8'hfb
`define K_FRAC 8

`endif

/* verif/front_end.sv */
module front_end #(
    parameter int CONV_CYC = 50
) (
    input wire logic clk,
    input wire logic conv_start_q,
    input wire logic [2:0] conv_chan_q,
    output logic [15:0] adc_value,
    output logic adc_open,
    output logic adc_over
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] val [8] = '{default: 16'h0000};
    logic [7:0] open_ch = 8'h00;
    logic [7:0] over_ch = 8'h00;
    int cnt = 0;
    bit ok;
    always @(posedge clk) cnt <= conv_start_q ? 0 : cnt + 1;
    // lines are inverse off the sampling edge, so early or late reads show
    always_comb begin
        ok = cnt == CONV_CYC - 2;
        adc_value = ok ? val[conv_chan_q] : ~val[conv_chan_q];
        adc_open = open_ch[conv_chan_q] ^ !ok;
        adc_over = over_ch[conv_chan_q] ^ !ok;
    end
endmodule // front_end

/* verif/testbench.sv */
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int CC = 50;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    logic unit_fahr = 1'b0, warn_blink = 1'b0;
    logic alarm_irq_en = 1'b1, pid_enable = 1'b0;
    logic [7:0] ch_enable = 8'h00, isr_number = 8'h28;
    logic [7:0] pid_reverse = 8'h00, irq_seen = 8'h00;
    logic [127:0] gain_flat = {8{16'h4000}};
    logic [127:0] offset_flat = 128'h0;
    logic [6:0] avg_depth = 7'h02;
    logic [2:0] pid_chan = 3'h0;
    logic [15:0] setpoint_value = 16'h0, proportional_gain = 16'h0100;
    logic [15:0] integral_gain = 16'h0, derivative_gain = 16'h0;
    logic [15:0] dead_band = 16'h0, out_max = 16'h0064, out_min = 16'h0;
    logic [15:0] samp_time = 16'h0004, adc_value;
    logic adc_open, adc_over, conv_start_q, result_valid_q;
    logic err_led_q, irq_req_q, pulse_out_q, prev;
    logic [2:0] conv_chan_q, result_chan_q;
    logic [127:0] temp_flat_q;
    logic [7:0] disc_alarm_q, range_alarm_q, irq_vector_q;
    logic [15:0] control_output_q, pulse_width_q;
    logic [15:0] sp_t [4] = '{16'h00fa, 16'h00fa, 16'h015e, 16'h0064};
    logic [15:0] db_t [4] = '{16'h0000, 16'h003c, 16'h0000, 16'h0000};
    logic [7:0] rv_t [4] = '{8'h00, 8'h00, 8'h01, 8'h00};
    logic [15:0] co_t [4] = '{16'h0032, 16'h0000, 16'h0032, 16'h0064};
    logic [15:0] pw_t [4] = '{16'h0002, 16'h0000, 16'h0002, 16'h0004};
    int n_fail = 0;
    int checks = 0;
    int hi;

    always #4 clk = ~clk;
    always @(posedge clk) if (irq_req_q === 1'b1) irq_seen <= irq_vector_q;

    front_end #(.CONV_CYC(CC)) fe (.clk(clk), .conv_start_q(conv_start_q),
        .conv_chan_q(conv_chan_q), .adc_value(adc_value),
        .adc_open(adc_open), .adc_over(adc_over));

    thermo_channels #(.CONV_CYC(CC), .SAMP_UNIT_CYC(20), .BLINK_CYC(10)) dut (
        .clk(clk), .rst_n(rst_n), .ce(ce), .ch_enable(ch_enable),
        .unit_fahr(unit_fahr), .gain_flat(gain_flat),
        .offset_flat(offset_flat), .avg_depth(avg_depth),
        .adc_value(adc_value), .adc_open(adc_open), .adc_over(adc_over),
        .warn_blink(warn_blink), .alarm_irq_en(alarm_irq_en),
        .isr_number(isr_number), .pid_enable(pid_enable),
        .pid_chan(pid_chan), .pid_reverse(pid_reverse),
        .setpoint_value(setpoint_value),
        .proportional_gain(proportional_gain),
        .integral_gain(integral_gain), .derivative_gain(derivative_gain),
        .dead_band(dead_band), .out_max(out_max), .out_min(out_min),
        .samp_time(samp_time), .conv_start_q(conv_start_q),
        .conv_chan_q(conv_chan_q), .temp_flat_q(temp_flat_q),
        .result_valid_q(result_valid_q), .result_chan_q(result_chan_q),
        .disc_alarm_q(disc_alarm_q), .range_alarm_q(range_alarm_q),
        .err_led_q(err_led_q), .irq_req_q(irq_req_q),
        .irq_vector_q(irq_vector_q), .control_output_q(control_output_q),
        .pulse_width_q(pulse_width_q), .pulse_out_q(pulse_out_q));

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wait_res(input logic [2:0] ch);
        int i;
        for (i = 0; i < 600; i++) begin
            @(posedge clk);
            if (result_valid_q === 1'b1 && result_chan_q === ch) break;
        end
        if (i == 600) begin
            n_fail++;
            close_out();
        end
        @(negedge clk);
    endtask

    task automatic res(input logic [2:0] ch, input logic [15:0] exp);
        wait_res(ch);
        chk(temp_flat_q[ch*16 +: 16], exp);
    endtask

    // two ch0 results always bracket one full slot of every other enabled channel
    task automatic scan();
        wait_res(3'h0);
        wait_res(3'h0);
    endtask

    task automatic close_out();
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial begin
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
        repeat (3) @(negedge clk);
        fe.val[0] = 16'h0064;
        fe.val[2] = 16'hffce;
        ch_enable = 8'h05;
        res(3'h0, 16'h0064);
        fe.val[0] = 16'h00c8;
        res(3'h0, 16'h0096);
        fe.val[0] = 16'h012c;
        res(3'h0, 16'h00fa);
        res(3'h2, 16'hffce);
        avg_depth = 7'h00;
        gain_flat[15:0] = 16'h4666;
        offset_flat[47:32] = 16'h0100;
        res(3'h2, 16'hffcf);
        res(3'h0, 16'h0149);
        gain_flat[15:0] = 16'h4000;
        unit_fahr = 1'b1;
        res(3'h2, 16'h00e7);
        res(3'h0, 16'h035c);
        unit_fahr = 1'b0;
        fe.open_ch = 8'h04;
        scan();
        chk({8'h00, disc_alarm_q}, 16'h0004);
        chk({8'h00, irq_seen}, 16'h0028);
        chk({15'h0, err_led_q}, 16'h0001);
        fe.open_ch = 8'h00;
        fe.over_ch = 8'h04;
        scan();
        chk({8'h00, range_alarm_q}, 16'h0004);
        chk({15'h0, err_led_q}, 16'h0001);
        warn_blink = 1'b1;
        repeat (12) @(negedge clk);
        hi = 0;
        prev = err_led_q;
        repeat (40) begin
            @(negedge clk);
            if (err_led_q !== prev) hi++;
            prev = err_led_q;
        end
        chk(hi[15:0], 16'h0004);
        ch_enable = 8'h01;
        isr_number = 8'hfb;
        scan();
        chk({8'h00, range_alarm_q}, 16'h0000);
        ch_enable = 8'h05;
        scan();
        chk({8'h00, range_alarm_q}, 16'h0004);
        chk({8'h00, irq_seen}, 16'h00fb);
        ch_enable = 8'h01;
        fe.over_ch = 8'h00;
        pid_enable = 1'b1;
        for (int k = 0; k < 4; k++) begin
            setpoint_value = sp_t[k];
            dead_band = db_t[k];
            pid_reverse = rv_t[k];
            repeat (250) @(negedge clk);
            chk(control_output_q, co_t[k]);
            chk(pulse_width_q, pw_t[k]);
            hi = 0;
            repeat (160) begin
                @(negedge clk);
                if (pulse_out_q === 1'b1) hi++;
            end
            chk(hi[15:0], pw_t[k] * 16'h0028);
        end
        close_out();
    end
endmodule // testbench

/* verif/thermo_channels_props.sv */
module thermo_checks #(
    parameter int CONV_CYC = 50
) (
    input wire clk,
    input wire rst_n,
    input wire [7:0] ch_enable,
    input wire warn_blink,
    input wire pid_enable,
    input wire conv_start_q,
    input wire [2:0] conv_chan_q,
    input wire [7:0] disc_alarm_q,
    input wire [7:0] range_alarm_q,
    input wire err_led_q,
    input wire irq_req_q,
    input wire [7:0] irq_vector_q,
    input wire pulse_out_q
);
    timeunit 1ns;
    timeprecision 1ps;
    int gap_q;
    logic seen_q;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            gap_q <= 0;
            seen_q <= 1'b0;
        end else begin
            gap_q <= conv_start_q ? 1 : gap_q + 1;
            seen_q <= seen_q | conv_start_q;
        end
    end
    a_start_single: assert property (
        conv_start_q |=> !conv_start_q) else $error("start pulse too long");
    a_slot_gap: assert property (
        conv_start_q && seen_q |-> gap_q >= CONV_CYC)
        else $error("conversion slot cut short");
    // the choice may be made a cycle before the start pulse
    a_start_enabled: assert property (
        conv_start_q |-> (((($past(ch_enable) | $past(ch_enable, 2))
        >> conv_chan_q) & 8'h01) != 8'h00)) else $error("disabled slot");
    a_alarm_excl: assert property (
        (disc_alarm_q & range_alarm_q) == 8'h00) else $error("alarm overlap");
    a_led_serious: assert property (
        (|disc_alarm_q) [*2] |-> err_led_q) else $error("led off on open");
    a_led_steady: assert property (
        (|range_alarm_q && !warn_blink) [*2] |-> err_led_q)
        else $error("led not steady");
    a_led_quiet: assert property (
        (disc_alarm_q == 8'h00 && range_alarm_q == 8'h00) [*2] |-> !err_led_q)
        else $error("led on without alarm");
    a_irq_range: assert property (
        irq_req_q |-> irq_vector_q >= 8'h28 && irq_vector_q <= 8'hfb)
        else $error("irq vector out of range");
    a_irq_single: assert property (
        irq_req_q |=> !irq_req_q) else $error("irq pulse too long");
    a_pulse_idle: assert property (
        !pid_enable |=> !pulse_out_q) else $error("pulse while idle");
endmodule // thermo_checks

bind thermo_channels thermo_checks #(.CONV_CYC(CONV_CYC)) u_chk (
    .clk(clk), .rst_n(rst_n), .ch_enable(ch_enable), .warn_blink(warn_blink),
    .pid_enable(pid_enable), .conv_start_q(conv_start_q),
    .conv_chan_q(conv_chan_q), .disc_alarm_q(disc_alarm_q),
    .range_alarm_q(range_alarm_q), .err_led_q(err_led_q),
    .irq_req_q(irq_req_q), .irq_vector_q(irq_vector_q),
    .pulse_out_q(pulse_out_q));
